// ===== uvtm_fault_resp.sv
// Purpose: UV and turn-on timeout fault response for one channel
// Assumes: Sequencer and comparator inputs are on CLK
// Notes: Command port carries one byte per access
`include "uvtm_defs.svh"

module uvtm_fault_resp (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Command byte access
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  output logic CMD_ACK,
  output logic [7:0] CMD_RDATA,
  // Clear events
  input wire logic CLEAR_FAULTS,
  input wire logic RESTORE_USER_ALL,
  input wire logic VENDOR_SOFT_RESET_COMMAND,
  // On command from pin and OPERATION combined
  input wire logic OUTPUT_ON_CMD,
  // Sequencer state
  input wire logic CHAN_ACTIVE,
  input wire logic TON_DELAY_DONE,
  input wire logic TON_RISE_DONE,
  input wire logic TON_RISING,
  input wire logic TOFF_FALLING,
  input wire logic TON_MAX_REACHED,
  // Comparators
  input wire logic UV_BELOW_LIMIT,
  input wire logic UV_WARN_RAW,
  input wire logic OC_PRESENT,
  input wire logic NONRETRY_SHUTDOWN,
  // Alert masks
  input wire logic MASK_UV,
  input wire logic MASK_TON,
  input wire logic MASK_CML,
  // Retry interval in 10 us steps
  input wire logic [15:0] RETRY_INTERVAL_SETTING,
  // Status bits
  output logic NONE_OF_THE_ABOVE,
  output logic VOUT_SUMMARY,
  output logic VOUT_UV_FAULT,
  output logic TON_MAX_FAULT,
  output logic CML_FAULT,
  output logic UV_WARN,
  // Alert open-drain pin
  output logic ALERT_OUT,
  output logic ALERT_OE,
  // Channel control
  output logic OUTPUT_ENABLE,
  output logic RESTART_REQ,
  output logic DISCONTINUOUS_MODE
);

  uvtm_pkg::uvtm_state_t s_ff;
  uvtm_pkg::uvtm_state_t nxt_s;

  logic uv_dgl_exp;
  logic ton_dgl_exp;
  logic uv_en;
  logic uv_event;
  logic ton_event;
  logic uv_dgl_run;
  logic ton_dgl_run;
  logic [1:0] uv_mode;
  logic [1:0] ton_mode;
  logic ton_enabled;

  // Response fields
  assign uv_mode = s_ff.uv_resp[`UVTM_RESP_HI:`UVTM_RESP_LO];
  assign ton_mode = s_ff.ton_resp[`UVTM_RESP_HI:`UVTM_RESP_LO];
  assign ton_enabled = (s_ff.ton_resp != 8'h00);

  // UV detection window
  assign uv_en = CHAN_ACTIVE
    && !TON_RISING && !TOFF_FALLING
    && TON_MAX_REACHED && TON_DELAY_DONE && TON_RISE_DONE
    && s_ff.crossed && !OC_PRESENT
    && (s_ff.run == uvtm_pkg::ST_RUN);

  assign uv_event = uv_en && UV_BELOW_LIMIT;
  assign ton_event = ton_enabled && CHAN_ACTIVE && TON_MAX_REACHED
    && !s_ff.crossed && (s_ff.run == uvtm_pkg::ST_RUN);

  assign uv_dgl_run = uv_event && (uv_mode == `UVTM_RESP_DEGLITCH);
  assign ton_dgl_run = ton_event && (ton_mode == `UVTM_RESP_DEGLITCH);

  uvtm_deglitch u_uv_dgl (
    .clk(CLK),
    .reset(RESET),
    .run(uv_dgl_run),
    .limit(s_ff.uv_resp[`UVTM_DELAY_HI:`UVTM_DELAY_LO]),
    .expired(uv_dgl_exp)
  );

  uvtm_deglitch u_ton_dgl (
    .clk(CLK),
    .reset(RESET),
    .run(ton_dgl_run),
    .limit(s_ff.ton_resp[`UVTM_DELAY_HI:`UVTM_DELAY_LO]),
    .expired(ton_dgl_exp)
  );

  always_comb begin
    logic clr;
    logic on_edge;
    logic uv_shut;
    logic ton_shut;
    logic [2:0] retry_sel;
    clr = 1'h0;
    on_edge = 1'h0;
    uv_shut = 1'h0;
    ton_shut = 1'h0;
    retry_sel = `UVTM_RETRY_NONE;
    nxt_s = s_ff;
    nxt_s.ack = 1'h0;
    nxt_s.restart = 1'h0;
    nxt_s.on_prev = OUTPUT_ON_CMD;

    // Off then on edge
    on_edge = OUTPUT_ON_CMD && !s_ff.on_prev;
    clr = CLEAR_FAULTS || on_edge || RESTORE_USER_ALL
      || VENDOR_SOFT_RESET_COMMAND;

    // Clear first so a same-cycle set wins
    if (clr) begin
      nxt_s.uv_flt = 1'h0;
      nxt_s.ton_flt = 1'h0;
      nxt_s.cml = 1'h0;
    end

    // Command byte access
    if (CMD_VALID) begin
      nxt_s.ack = 1'h1;
      nxt_s.rdata = 8'h00;
      case (CMD_CODE)
        `UVTM_CMD_UV_RESP: begin
          nxt_s.rdata = s_ff.uv_resp;
          if (CMD_WRITE) begin
            if (CMD_WDATA[`UVTM_RESP_HI:`UVTM_RESP_LO] == `UVTM_RESP_BAD) begin
              nxt_s.cml = 1'h1;
            end else begin
              nxt_s.uv_resp = CMD_WDATA;
            end
          end
        end
        `UVTM_CMD_TON_RESP: begin
          nxt_s.rdata = s_ff.ton_resp;
          if (CMD_WRITE) begin
            if (CMD_WDATA[`UVTM_RESP_HI:`UVTM_RESP_LO] == `UVTM_RESP_BAD) begin
              nxt_s.cml = 1'h1;
            end else begin
              nxt_s.ton_resp = CMD_WDATA;
            end
          end
        end
        `UVTM_CMD_OC_RESP: begin
          nxt_s.rdata = s_ff.oc_resp;
          if (CMD_WRITE) begin
            nxt_s.oc_resp = CMD_WDATA;
          end
        end
        default: begin
          nxt_s.cml = 1'h1;
        end
      endcase
    end

    // Output crossed the UV limit since start
    if (!CHAN_ACTIVE) begin
      nxt_s.crossed = 1'h0;
    end else if (!UV_BELOW_LIMIT) begin
      nxt_s.crossed = 1'h1;
    end

    // Timeout fault reported once per start
    if (!CHAN_ACTIVE) begin
      nxt_s.ton_seen = 1'h0;
    end

    // UV fault flag, all responses
    if (uv_event) begin
      nxt_s.uv_flt = 1'h1;
    end
    if (ton_event && !s_ff.ton_seen) begin
      nxt_s.ton_flt = 1'h1;
      nxt_s.ton_seen = 1'h1;
    end

    // Warning uses the same mask window
    nxt_s.uv_warn = uv_en && UV_WARN_RAW;

    // Shutdown decisions per response field
    case (uv_mode)
      `UVTM_RESP_IGNORE: uv_shut = 1'h0;
      `UVTM_RESP_DEGLITCH: uv_shut = uv_dgl_exp && uv_event;
      `UVTM_RESP_SHUTDOWN: uv_shut = uv_event;
      default: uv_shut = 1'h0;
    endcase
    case (ton_mode)
      `UVTM_RESP_IGNORE: ton_shut = 1'h0;
      `UVTM_RESP_DEGLITCH: ton_shut = ton_dgl_exp && ton_event;
      `UVTM_RESP_SHUTDOWN: ton_shut = ton_event;
      default: ton_shut = 1'h0;
    endcase
    if (uv_shut) begin
      retry_sel = s_ff.uv_resp[`UVTM_RETRY_HI:`UVTM_RETRY_LO];
    end else if (ton_shut) begin
      retry_sel = s_ff.ton_resp[`UVTM_RETRY_HI:`UVTM_RETRY_LO];
    end

    // Run control
    case (s_ff.run)
      uvtm_pkg::ST_OFF: begin
        if (OUTPUT_ON_CMD) begin
          nxt_s.run = uvtm_pkg::ST_RUN;
        end
      end
      uvtm_pkg::ST_RUN: begin
        if (NONRETRY_SHUTDOWN) begin
          nxt_s.run = uvtm_pkg::ST_LATCHED;
        end else if (uv_shut || ton_shut) begin
          if (retry_sel == `UVTM_RETRY_NONE) begin
            nxt_s.run = uvtm_pkg::ST_LATCHED;
          end else begin
            nxt_s.run = uvtm_pkg::ST_RETRY_WAIT;
            nxt_s.retry_cnt = RETRY_INTERVAL_SETTING;
            nxt_s.tick_cnt = 9'h000;
          end
        end
      end
      uvtm_pkg::ST_LATCHED: begin
        if (CLEAR_FAULTS) begin
          nxt_s.run = uvtm_pkg::ST_RUN;
          nxt_s.restart = 1'h1;
        end
      end
      uvtm_pkg::ST_RETRY_WAIT: begin
        if (NONRETRY_SHUTDOWN) begin
          nxt_s.run = uvtm_pkg::ST_LATCHED;
        end else if (s_ff.retry_cnt == 16'h0000) begin
          nxt_s.run = uvtm_pkg::ST_RUN;
          nxt_s.restart = 1'h1;
        end else if (s_ff.tick_cnt == 9'(`UVTM_TICK_CYCLES - 1)) begin
          nxt_s.tick_cnt = 9'h000;
          nxt_s.retry_cnt = s_ff.retry_cnt - 16'h0001;
        end else begin
          nxt_s.tick_cnt = s_ff.tick_cnt + 9'h001;
        end
      end
      default: begin
        nxt_s.run = uvtm_pkg::ST_OFF;
      end
    endcase

    // Commanded off overrides every state
    if (!OUTPUT_ON_CMD) begin
      nxt_s.run = uvtm_pkg::ST_OFF;
      nxt_s.restart = 1'h0;
    end

    nxt_s.out_en = (nxt_s.run == uvtm_pkg::ST_RUN);
    nxt_s.disc = nxt_s.out_en && !TON_MAX_REACHED;

    // Alert from unmasked flags
    nxt_s.alert = (nxt_s.uv_flt && !MASK_UV)
      || (nxt_s.ton_flt && !MASK_TON)
      || (nxt_s.cml && !MASK_CML);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_ff <= '0;
      s_ff.run <= uvtm_pkg::ST_OFF;
      s_ff.uv_resp <= `UVTM_UV_RESP_RST;
      s_ff.ton_resp <= `UVTM_TON_RESP_RST;
      s_ff.oc_resp <= `UVTM_OC_RESP_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign CMD_ACK = s_ff.ack;
  assign CMD_RDATA = s_ff.rdata;
  assign VOUT_UV_FAULT = s_ff.uv_flt;
  assign TON_MAX_FAULT = s_ff.ton_flt;
  assign VOUT_SUMMARY = s_ff.uv_flt || s_ff.ton_flt;
  assign NONE_OF_THE_ABOVE = s_ff.uv_flt || s_ff.ton_flt;
  assign CML_FAULT = s_ff.cml;
  assign UV_WARN = s_ff.uv_warn;
  assign ALERT_OUT = 1'h0;
  assign ALERT_OE = s_ff.alert;
  assign OUTPUT_ENABLE = s_ff.out_en;
  assign RESTART_REQ = s_ff.restart;
  assign DISCONTINUOUS_MODE = s_ff.disc;

endmodule

// ===== uvtm_defs.svh
// Purpose: Constants for the undervoltage and turn-on timeout fault response
// Assumes: 50 MHz CLK, one output channel, commands reached by code
// Notes: Offsets are command codes, one data byte each
//
// What this block does
// - UV fault sets three status bits
// - Flagged fault drives alert unless masked
// - UV detect waits for full start criteria
// - UV detect masked while channel inactive
// - UV detect masked during rise and fall
// - Response 00 flags only, keeps running
// - Response 01 runs delay, then retry setting
// - Response 10 shuts down at once, then retry
// - Writing response 11 to UV or timeout raises CML fault
// - Fault bits clear only on listed events
// - Retry 000 stays off until cleared
// - Delay field counts 10 us steps
// - Timeout fault sets status and alerts
// - Timeout response zero disables that response
// - Discontinuous mode until timeout limit exceeded
// - Each command moves exactly one byte
// - Overcurrent response at 0x47, default 0x00
// - Undervoltage response at 0x45, default 0xB8
// - Timeout response at 0x63, default 0xB8
`ifndef UVTM_DEFS_SVH
`define UVTM_DEFS_SVH

`define UVTM_CMD_OC_RESP 8'h47
`define UVTM_CMD_UV_RESP 8'h45
`define UVTM_CMD_TON_RESP 8'h63
`define UVTM_OC_RESP_RST 8'h00
`define UVTM_UV_RESP_RST 8'hB8
`define UVTM_TON_RESP_RST 8'hB8

`define UVTM_RESP_HI 7
`define UVTM_RESP_LO 6
`define UVTM_RETRY_HI 5
`define UVTM_RETRY_LO 3
`define UVTM_DELAY_HI 2
`define UVTM_DELAY_LO 0

`define UVTM_RESP_IGNORE 2'h0
`define UVTM_RESP_DEGLITCH 2'h1
`define UVTM_RESP_SHUTDOWN 2'h2
`define UVTM_RESP_BAD 2'h3
`define UVTM_RETRY_NONE 3'h0

`define UVTM_TICK_US 10
`define UVTM_CLK_NS 20
`define UVTM_TICK_CYCLES ((`UVTM_TICK_US * 1000) / `UVTM_CLK_NS)

`endif

// ===== uvtm_pkg.sv
// Purpose: Types for the fault response block
// Assumes: Constants come from uvtm_defs.svh
// Notes: State of each module is one packed struct
package uvtm_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_LATCHED,
    ST_RETRY_WAIT
  } uvtm_run_t;

  typedef struct packed {
    logic [8:0] cyc;
    logic [2:0] ticks;
    logic expired;
  } uvtm_dgl_t;

  typedef struct packed {
    uvtm_run_t run;
    logic [7:0] uv_resp;
    logic [7:0] ton_resp;
    logic [7:0] oc_resp;
    logic [7:0] rdata;
    logic ack;
    logic uv_flt;
    logic ton_flt;
    logic cml;
    logic alert;
    logic out_en;
    logic restart;
    logic on_prev;
    logic crossed;
    logic ton_seen;
    logic uv_warn;
    logic disc;
    logic [15:0] retry_cnt;
    logic [8:0] tick_cnt;
  } uvtm_state_t;

endpackage

// ===== uvtm_deglitch.sv
// Purpose: Counts how long a fault persists in 10 us steps
// Assumes: Run is high only while the fault is present
// Notes: Expired is a registered level while the time is reached
`include "uvtm_defs.svh"

module uvtm_deglitch (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fault persistence
  input wire logic run,
  input wire logic [2:0] limit,
  output logic expired
);

  uvtm_pkg::uvtm_dgl_t s_ff;
  uvtm_pkg::uvtm_dgl_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.expired = 1'h0;
    if (!run) begin
      // Fault gone, start over next time
      nxt_s.cyc = 9'h000;
      nxt_s.ticks = 3'h0;
    end else if (s_ff.ticks >= limit) begin
      nxt_s.expired = 1'h1;
    end else if (s_ff.cyc == 9'(`UVTM_TICK_CYCLES - 1)) begin
      nxt_s.cyc = 9'h000;
      nxt_s.ticks = s_ff.ticks + 3'h1;
    end else begin
      nxt_s.cyc = s_ff.cyc + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign expired = s_ff.expired;

endmodule

// ===== uvtm_fault_resp_asserts.sv
// Purpose: Port checks for uvtm_fault_resp
// Assumes: One clock, sync reset
// Notes: Mirrors UV and timeout response bytes from writes
module uvtm_fault_resp_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Command port
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  input wire logic CMD_ACK,
  // Events and sequencer
  input wire logic CLEAR_FAULTS,
  input wire logic RESTORE_USER_ALL,
  input wire logic VENDOR_SOFT_RESET_COMMAND,
  input wire logic OUTPUT_ON_CMD,
  input wire logic CHAN_ACTIVE,
  input wire logic TON_RISING,
  input wire logic TOFF_FALLING,
  input wire logic TON_MAX_REACHED,
  input wire logic OC_PRESENT,
  input wire logic MASK_UV,
  // Outputs
  input wire logic NONE_OF_THE_ABOVE,
  input wire logic VOUT_SUMMARY,
  input wire logic VOUT_UV_FAULT,
  input wire logic TON_MAX_FAULT,
  input wire logic CML_FAULT,
  input wire logic UV_WARN,
  input wire logic ALERT_OE,
  input wire logic OUTPUT_ENABLE,
  input wire logic DISCONTINUOUS_MODE
);
  logic [7:0] uv_ff;
  logic [7:0] ton_ff;
  logic wr_ok;
  logic clr;
  assign wr_ok = CMD_VALID && CMD_WRITE && CMD_WDATA[7:6] != 2'h3;
  assign clr = CLEAR_FAULTS || RESTORE_USER_ALL || VENDOR_SOFT_RESET_COMMAND;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      uv_ff <= 8'hB8;
      ton_ff <= 8'hB8;
    end else if (wr_ok && CMD_CODE == 8'h45) begin
      uv_ff <= CMD_WDATA;
    end else if (wr_ok && CMD_CODE == 8'h63) begin
      ton_ff <= CMD_WDATA;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  a_ack_per_byte: assert property (CMD_VALID |=> CMD_ACK)
    else $error("no ack");
  a_uv_status: assert property ($rose(VOUT_UV_FAULT) |->
    NONE_OF_THE_ABOVE && VOUT_SUMMARY) else $error("uv status");
  a_uv_alert: assert property ($rose(VOUT_UV_FAULT) && !$past(MASK_UV)
    |-> ALERT_OE) else $error("uv alert");
  a_uv_window: assert property (!CHAN_ACTIVE || TON_RISING || TOFF_FALLING
    || !TON_MAX_REACHED || OC_PRESENT |=> !$rose(VOUT_UV_FAULT))
    else $error("uv outside window");
  a_warn_inactive: assert property (!CHAN_ACTIVE |=> !UV_WARN)
    else $error("warn inactive");
  a_uv_sticky: assert property (VOUT_UV_FAULT && !clr
    && !$rose(OUTPUT_ON_CMD) |=> VOUT_UV_FAULT) else $error("uv lost");
  a_mode_off: assert property ($rose(VOUT_UV_FAULT) && uv_ff[7:6] == 2'h2
    |-> !OUTPUT_ENABLE) else $error("no shutdown");
  a_mode_ignore: assert property ($rose(VOUT_UV_FAULT) && uv_ff[7:6] == 2'h0
    |-> OUTPUT_ENABLE [*2]) else $error("ignore stopped");
  a_bad_resp: assert property (CMD_VALID && CMD_WRITE &&
    CMD_WDATA[7:6] == 2'h3 && (CMD_CODE == 8'h45 || CMD_CODE == 8'h63)
    |=> CML_FAULT) else $error("no cml");
  a_ton_off: assert property (ton_ff == 8'h00 |=> !$rose(TON_MAX_FAULT))
    else $error("ton while disabled");
  a_ton_status: assert property ($rose(TON_MAX_FAULT) |->
    NONE_OF_THE_ABOVE && VOUT_SUMMARY) else $error("ton status");
  a_disc_mode: assert property (DISCONTINUOUS_MODE ==
    (OUTPUT_ENABLE && !$past(TON_MAX_REACHED))) else $error("disc mode");
  c_uv: cover property ($rose(VOUT_UV_FAULT));
  c_ton: cover property ($rose(TON_MAX_FAULT));
  c_cml: cover property ($rose(CML_FAULT));
endmodule

bind uvtm_fault_resp uvtm_fault_resp_asserts chk (.*);

// ===== uvtm_host_model.sv
// Purpose: Host side of the command byte port
// Assumes: Called 1 ns after a CLK rise
// Notes: Holds each request until ack is sampled or 4 edges pass
module uvtm_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end
  // One whole byte per access; zero timeout byte only when told
  task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    int i;
    ok = 1'b0;
    q = 8'h00;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (cmd_ack === 1'b1) begin
        ok = 1'b1;
        q = cmd_rdata;
      end
    end
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
    // Let an edge pass so a following call never re-drives in this step
    @(posedge clk);
    #1;
  endtask
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for uvtm_fault_resp
// Assumes: Inputs change 1 ns after CLK rise
// Notes: LFSR from 98 picks data and masks
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RESET, CMD_VALID, CMD_WRITE, CMD_ACK, CLEAR_FAULTS;
  logic RESTORE_USER_ALL, VENDOR_SOFT_RESET_COMMAND, OUTPUT_ON_CMD;
  logic CHAN_ACTIVE, TON_DELAY_DONE, TON_RISE_DONE, TON_RISING;
  logic TOFF_FALLING, TON_MAX_REACHED, UV_BELOW_LIMIT, UV_WARN_RAW;
  logic OC_PRESENT, NONRETRY_SHUTDOWN, MASK_UV, MASK_TON, MASK_CML;
  logic NONE_OF_THE_ABOVE, VOUT_SUMMARY, VOUT_UV_FAULT, TON_MAX_FAULT;
  logic CML_FAULT, UV_WARN, ALERT_OUT, ALERT_OE, OUTPUT_ENABLE;
  logic RESTART_REQ, DISCONTINUOUS_MODE;
  logic [7:0] CMD_CODE, CMD_WDATA, CMD_RDATA, q, lf;
  logic [15:0] RETRY_INTERVAL_SETTING;
  int err_count, checks, i;
  uvtm_fault_resp dut (.*);
  uvtm_host_model host (.clk(CLK), .cmd_valid(CMD_VALID),
    .cmd_write(CMD_WRITE), .cmd_code(CMD_CODE), .cmd_wdata(CMD_WDATA),
    .cmd_ack(CMD_ACK), .cmd_rdata(CMD_RDATA));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic exp_en(input int m);
    return m == 0;
  endfunction
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d);
    logic ok;
    host.acc(w, c, d, q, ok);
    if (!ok) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic up(input logic t);
    {OUTPUT_ON_CMD, CHAN_ACTIVE, TON_RISING, UV_BELOW_LIMIT} = 4'hF;
    cyc(4);
    chk("disc", DISCONTINUOUS_MODE, 1);
    chk("uv rise", VOUT_UV_FAULT, 0);
    {TON_RISING, TON_DELAY_DONE, TON_RISE_DONE} = 3'h3;
    TON_MAX_REACHED = t;
    UV_BELOW_LIMIT = t;
    cyc(3);
    UV_BELOW_LIMIT = 1'b0;
    TON_MAX_REACHED = 1'b1;
    cyc(3);
    chk("disc end", DISCONTINUOUS_MODE, 0);
  endtask
  task automatic down();
    {TOFF_FALLING, UV_BELOW_LIMIT} = 2'h3;
    cyc(3);
    {OUTPUT_ON_CMD, CHAN_ACTIVE, TOFF_FALLING} = 3'h0;
    {TON_DELAY_DONE, TON_RISE_DONE, TON_MAX_REACHED} = 3'h0;
    cyc(3);
    chk("warn off", UV_WARN, 0);
  endtask
  initial begin
    RESET = 1'b1;
    {CLEAR_FAULTS, RESTORE_USER_ALL, VENDOR_SOFT_RESET_COMMAND} = 3'h0;
    {OUTPUT_ON_CMD, CHAN_ACTIVE, TON_DELAY_DONE, TON_RISE_DONE} = 4'h0;
    {TON_RISING, TOFF_FALLING, TON_MAX_REACHED, UV_BELOW_LIMIT} = 4'h0;
    {OC_PRESENT, NONRETRY_SHUTDOWN, MASK_UV, MASK_TON, MASK_CML} = 5'h0;
    UV_WARN_RAW = 1'b1;
    RETRY_INTERVAL_SETTING = 16'h0001;
    err_count = 0;
    checks = 0;
    lf = 8'h62;
    cyc(5);
    RESET = 1'b0;
    acc(1'b0, 8'h45, 8'h00);
    chk("uv byte", q, 8'hB8);
    acc(1'b0, 8'h63, 8'h00);
    chk("ton byte", q, 8'hB8);
    acc(1'b0, 8'h47, 8'h00);
    chk("oc byte", q, 8'h00);
    lf = nxt(lf);
    acc(1'b1, 8'h47, lf);
    acc(1'b0, 8'h47, 8'h00);
    chk("oc rw", q, lf);
    for (i = 0; i < 3; i++) begin
      lf = nxt(lf);
      MASK_CML = lf[1];
      acc(1'b1, 8'h45, lf | 8'hC0);
      cyc(1);
      chk("cml", CML_FAULT, 1);
      chk("cml alert", ALERT_OE, !lf[1]);
      chk("alert pin", ALERT_OUT, 0);
      acc(1'b0, 8'h45, 8'h00);
      chk("uv kept", q, 8'hB8);
      {CLEAR_FAULTS, RESTORE_USER_ALL, VENDOR_SOFT_RESET_COMMAND} = 3'h4 >> i;
      cyc(1);
      {CLEAR_FAULTS, RESTORE_USER_ALL, VENDOR_SOFT_RESET_COMMAND} = 3'h0;
      cyc(1);
      chk("cml clr", CML_FAULT, 0);
      chk("alert clr", ALERT_OE, 0);
    end
    MASK_CML = 1'b0;
    for (i = 0; i < 2; i++) begin
      lf = nxt(lf);
      MASK_UV = lf[0];
      acc(1'b1, 8'h45, i ? 8'h80 : 8'h00);
      up(1'b0);
      {OC_PRESENT, UV_BELOW_LIMIT} = 2'h3;
      cyc(3);
      chk("uv oc", VOUT_UV_FAULT, 0);
      OC_PRESENT = 1'b0;
      cyc(3);
      chk("uv set", {VOUT_UV_FAULT, NONE_OF_THE_ABOVE, VOUT_SUMMARY}, 7);
      chk("alert", ALERT_OE, !lf[0]);
      chk("run", OUTPUT_ENABLE, exp_en(i));
      cyc(600);
      chk("latched", OUTPUT_ENABLE, exp_en(i));
      UV_BELOW_LIMIT = 1'b0;
      CLEAR_FAULTS = 1'b1;
      cyc(1);
      CLEAR_FAULTS = 1'b0;
      cyc(2);
      chk("uv clr", VOUT_UV_FAULT, 0);
      down();
    end
    acc(1'b1, 8'h45, 8'h79);
    up(1'b0);
    UV_BELOW_LIMIT = 1'b1;
    cyc(300);
    UV_BELOW_LIMIT = 1'b0;
    cyc(2);
    UV_BELOW_LIMIT = 1'b1;
    cyc(300);
    chk("deglitch", OUTPUT_ENABLE, 1);
    cyc(220);
    chk("dgl end", OUTPUT_ENABLE, 0);
    UV_BELOW_LIMIT = 1'b0;
    for (i = 0; i < 600 && RESTART_REQ !== 1'b1; i++) cyc(1);
    chk("retry", RESTART_REQ, 1);
    if (i == 600) print_verdict();
    cyc(2);
    chk("rerun", OUTPUT_ENABLE, 1);
    down();
    acc(1'b1, 8'h63, 8'h00);
    up(1'b1);
    chk("ton off", TON_MAX_FAULT, 0);
    down();
    acc(1'b1, 8'h63, 8'hB8);
    up(1'b1);
    chk("ton", {TON_MAX_FAULT, NONE_OF_THE_ABOVE, ALERT_OE}, 7);
    down();
    print_verdict();
  end
endmodule
